/* File: rtl/ccsc_charge_ctrl.sv */
// Purpose: charge cycle sequencing, faults and open-drain status
// Assumes: comparator flags asynchronous, straps synchronous
// Notes:   apb slave answers with no wait state
`timescale 1ns/1ps
`include "ccsc_defines.svh"

module ccsc_charge_ctrl #(
	parameter logic [31:0] SAFETY_TICKS =
		32'(`CCSC_SAFETY_HOURS * 3600 * (1000000 / `CCSC_TICK_US))
) (
	input  wire logic                mclk_i,
	input  wire logic                resetn_i,
	input  wire ccsc_pkg::ccsc_flags_t flags_i,
	input  wire logic                charge_enable_i,
	input  wire logic                safety_timer_enable_n_i,
	input  wire logic                psel_i,
	input  wire logic                penable_i,
	input  wire logic                pwrite_i,
	input  wire logic [11:0]         paddr_i,
	input  wire logic [31:0]         pwdata_i,
	output logic      [31:0]         prdata_o,
	output logic                     pready_o,
	output logic                     pslverr_o,
	output logic                     charge_on_o,
	output logic                     current_tenth_o,
	output logic                     cv_mode_o,
	output logic                     current_reduce_o,
	output logic                     battery_path_on_o,
	output logic                     charge_status_a_n_o,
	output logic                     charge_status_a_n_oe_o,
	output logic                     charge_status_b_n_o,
	output logic                     charge_status_b_n_oe_o,
	output logic                     input_good_n_o,
	output logic                     input_good_n_oe_o
);

	localparam int NF = $bits(ccsc_pkg::ccsc_flags_t);
	localparam logic [7:0] TICK_CYC =
		8'(`CCSC_TICK_US * `CCSC_CLK_MHZ);
	// one tick extra so a full filter period is always seen
	localparam logic [6:0] FILT_TICKS =
		7'(`CCSC_TERM_FILT_US / `CCSC_TICK_US + 1);

	ccsc_pkg::ccsc_state_t state_q;
	ccsc_pkg::ccsc_state_t state_d;
	ccsc_pkg::ccsc_flags_t s;
	logic [NF-1:0]         meta_q;
	logic [NF-1:0]         sync_q;
	logic [7:0]            tick_cnt_q;
	logic                  tick_q;
	logic [31:0]           timer_q;
	logic [6:0]            filt_q;
	logic                  tsusp_q;
	logic                  dsusp_q;
	logic                  hold_q;
	logic                  timer_exp;
	logic                  term_done;
	logic                  charging;
	logic                  susp;
	logic                  run_ok;
	logic                  pg_now;

	// two-flop synchronisers, one per comparator flag
	generate
		for (genvar i = 0; i < NF; i++)
		begin : g_sync
			always_ff @(posedge mclk_i or negedge resetn_i)
			begin
				if (!resetn_i)
				begin
					meta_q[i] <= 1'b0;
					sync_q[i] <= 1'b0;
				end
				else
				begin
					meta_q[i] <= flags_i[i];
					sync_q[i] <= meta_q[i];
				end
			end
		end
	endgenerate
	assign s = ccsc_pkg::ccsc_flags_t'(sync_q);

	// fixed-rate tick for timer and filter
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			tick_cnt_q <= 8'h00;
			tick_q     <= 1'b0;
		end
		else if (tick_cnt_q == TICK_CYC - 8'h01)
		begin
			tick_cnt_q <= 8'h00;
			tick_q     <= 1'b1;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_q + 8'h01;
			tick_q     <= 1'b0;
		end
	end

	// derived conditions
	assign charging  = (state_q == ccsc_pkg::ST_PRECOND) ||
	                   (state_q == ccsc_pkg::ST_FAST) ||
	                   (state_q == ccsc_pkg::ST_CV);
	assign susp      = tsusp_q || dsusp_q || hold_q;
	assign run_ok    = s.in_present && charge_enable_i;
	assign timer_exp = !safety_timer_enable_n_i &&
	                   (timer_q >= SAFETY_TICKS);
	assign term_done = (filt_q == FILT_TICKS);
	assign pg_now    = s.in_present;

	// battery temperature suspension, immediate both ways
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			tsusp_q <= 1'b0;
		else
			tsusp_q <= charging && !s.thermistor_sense_ok;
	end

	// die shutdown with hysteresis between trip and cooled flags
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			dsusp_q <= 1'b0;
		else if (s.die_hot)
			dsusp_q <= 1'b1;
		else if (s.die_cooled)
			dsusp_q <= 1'b0;
	end

	// safety timer: cleared on qualify and fast entry, frozen in suspend
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			timer_q <= 32'h0000_0000;
		else if (state_q == ccsc_pkg::ST_QUAL)
			timer_q <= 32'h0000_0000;
		else if (state_d == ccsc_pkg::ST_FAST &&
		         state_q != ccsc_pkg::ST_FAST)
			timer_q <= 32'h0000_0000;
		else if (charging && tick_q && !susp && !timer_exp &&
		         !safety_timer_enable_n_i)
			timer_q <= timer_q + 32'h0000_0001;
	end

	// termination filter: condition must hold for every tick
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			filt_q <= 7'h00;
		else if (state_q != ccsc_pkg::ST_CV || !s.term_below || susp)
			filt_q <= 7'h00;
		else if (tick_q && !term_done)
			filt_q <= filt_q + 7'h01;
	end

	// next state
	always_comb
	begin
		state_d = state_q;
		if (!run_ok)
			state_d = ccsc_pkg::ST_OFF;
		else
		begin
			case (state_q)
				ccsc_pkg::ST_OFF:
					state_d = ccsc_pkg::ST_QUAL;
				ccsc_pkg::ST_NOBAT:
					if (s.bat_present)
						state_d = ccsc_pkg::ST_QUAL;
				ccsc_pkg::ST_QUAL:
					if (!s.bat_present)
						state_d = ccsc_pkg::ST_NOBAT;
					else if (!s.above_precond)
						state_d = ccsc_pkg::ST_PRECOND;
					else
						state_d = ccsc_pkg::ST_FAST;
				ccsc_pkg::ST_PRECOND:
					if (!s.bat_present)
						state_d = ccsc_pkg::ST_NOBAT;
					else if (timer_exp)
						state_d = ccsc_pkg::ST_TFAULT;
					else if (s.above_precond)
						state_d = ccsc_pkg::ST_FAST;
				ccsc_pkg::ST_FAST:
					if (!s.bat_present)
						state_d = ccsc_pkg::ST_NOBAT;
					else if (timer_exp)
						state_d = ccsc_pkg::ST_TFAULT;
					else if (s.at_reg)
						state_d = ccsc_pkg::ST_CV;
				ccsc_pkg::ST_CV:
					if (!s.bat_present)
						state_d = ccsc_pkg::ST_NOBAT;
					else if (term_done || timer_exp)
						state_d = ccsc_pkg::ST_COMPLETE;
				ccsc_pkg::ST_COMPLETE:
					if (!s.bat_present)
						state_d = ccsc_pkg::ST_NOBAT;
					else if (s.below_recharge)
						state_d = ccsc_pkg::ST_QUAL;
				ccsc_pkg::ST_TFAULT:
					if (!s.bat_present)
						state_d = ccsc_pkg::ST_NOBAT;
				default:
					state_d = ccsc_pkg::ST_OFF;
			endcase
		end
	end

	// state register
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			state_q <= ccsc_pkg::ST_OFF;
		else
			state_q <= state_d;
	end

	// charge path commands
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			charge_on_o       <= 1'b0;
			current_tenth_o   <= 1'b0;
			cv_mode_o         <= 1'b0;
			current_reduce_o  <= 1'b0;
			battery_path_on_o <= 1'b0;
		end
		else
		begin
			charge_on_o       <= charging && !susp;
			current_tenth_o   <= state_q == ccsc_pkg::ST_PRECOND;
			cv_mode_o         <= state_q == ccsc_pkg::ST_CV;
			current_reduce_o  <= (s.vin_at_fold && !s.fold_tied_in) ||
			                     s.iin_at_limit;
			battery_path_on_o <= !s.in_present || s.sys_over ||
			                     s.iin_at_limit;
		end
	end

	// open-drain status: enable high means pin pulled low
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			charge_status_a_n_o    <= 1'b0;
			charge_status_b_n_o    <= 1'b0;
			input_good_n_o         <= 1'b0;
			charge_status_a_n_oe_o <= 1'b0;
			charge_status_b_n_oe_o <= 1'b0;
			input_good_n_oe_o      <= 1'b0;
		end
		else
		begin
			charge_status_a_n_o <= 1'b0;
			charge_status_b_n_o <= 1'b0;
			input_good_n_o      <= 1'b0;
			input_good_n_oe_o   <= pg_now;
			if (!s.in_present)
			begin
				charge_status_a_n_oe_o <= s.bat_low;
				charge_status_b_n_oe_o <= 1'b0;
			end
			else if (state_q == ccsc_pkg::ST_TFAULT ||
			         (charging && tsusp_q))
			begin
				charge_status_a_n_oe_o <= 1'b1;
				charge_status_b_n_oe_o <= 1'b1;
			end
			else if (charging)
			begin
				charge_status_a_n_oe_o <= 1'b1;
				charge_status_b_n_oe_o <= 1'b0;
			end
			else if (state_q == ccsc_pkg::ST_COMPLETE)
			begin
				charge_status_a_n_oe_o <= 1'b0;
				charge_status_b_n_oe_o <= 1'b1;
			end
			else
			begin
				charge_status_a_n_oe_o <= 1'b0;
				charge_status_b_n_oe_o <= 1'b0;
			end
		end
	end

	// apb slave: no wait state, error on unmapped or read-only write
	logic apb_setup;
	logic apb_hit;
	assign apb_setup = psel_i && !penable_i && !pready_o;
	assign apb_hit   = paddr_i == `CCSC_CTRL_OFF ||
	                   paddr_i == `CCSC_STATUS_OFF ||
	                   paddr_i == `CCSC_TIMER_OFF;

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end
		else
		begin
			pready_o  <= apb_setup;
			pslverr_o <= apb_setup && (!apb_hit ||
			             (pwrite_i && paddr_i != `CCSC_CTRL_OFF));
			prdata_o  <= 32'h0000_0000;
			if (apb_setup && !pwrite_i)
			begin
				case (paddr_i)
					`CCSC_CTRL_OFF:
						prdata_o <= {31'h0, hold_q};
					`CCSC_STATUS_OFF:
						prdata_o <= {20'h0, current_reduce_o, timer_exp,
						             dsusp_q, tsusp_q, state_q};
					`CCSC_TIMER_OFF:
						prdata_o <= timer_q;
					default:
						prdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// control register: software hold suspends charging
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			hold_q <= 1'b0;
		else if (psel_i && penable_i && pready_o && pwrite_i &&
		         paddr_i == `CCSC_CTRL_OFF)
			hold_q <= pwdata_i[`CCSC_CTRL_HOLD_BIT];
	end

	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	timer_fault_a: assert property (
		$rose(state_q == ccsc_pkg::ST_TFAULT) |->
		$past(state_q == ccsc_pkg::ST_FAST ||
		      state_q == ccsc_pkg::ST_PRECOND) && $past(timer_exp))
		else $error("timer fault without expiry in charge");
	fault_latch_a: assert property (
		state_q == ccsc_pkg::ST_TFAULT && run_ok && s.bat_present |=>
		state_q == ccsc_pkg::ST_TFAULT)
		else $error("timer fault left while battery present");
	cc_to_cv_a: assert property (
		state_q == ccsc_pkg::ST_FAST && run_ok && s.bat_present &&
		!timer_exp && s.at_reg |=> state_q == ccsc_pkg::ST_CV)
		else $error("regulation reached but no cv");
	term_entry_a: assert property (
		$rose(state_q == ccsc_pkg::ST_COMPLETE) |->
		$past(state_q == ccsc_pkg::ST_CV) &&
		($past(term_done) || $past(timer_exp)))
		else $error("complete entered without termination");
	filter_hold_a: assert property (
		state_q == ccsc_pkg::ST_CV && !timer_exp && !term_done |=>
		state_q != ccsc_pkg::ST_COMPLETE)
		else $error("termination before filter elapsed");
	freeze_timer_a: assert property (
		susp && state_q == $past(state_q) && $past(susp) && charging |->
		timer_q == $past(timer_q))
		else $error("timer moved during suspension");
	pass_off_a: assert property (
		tsusp_q |=> !charge_on_o)
		else $error("pass device on during temperature suspend");
	never_high_a: assert property (
		!charge_status_a_n_o && !charge_status_b_n_o && !input_good_n_o)
		else $error("status pin driven high");
	complete_led_a: assert property (
		state_q == ccsc_pkg::ST_COMPLETE && s.in_present |=>
		!charge_status_a_n_oe_o && charge_status_b_n_oe_o)
		else $error("wrong status in charge complete");
	fast_clear_a: assert property (
		$rose(state_q == ccsc_pkg::ST_FAST) |-> timer_q == 32'h0)
		else $error("timer not cleared on fast entry");
	qual_clear_a: assert property (
		state_q == ccsc_pkg::ST_QUAL |=> timer_q == 32'h0000_0000)
		else $error("timer not cleared on qualification");

	reach_complete_c: cover property (
		state_q == ccsc_pkg::ST_CV ##1 state_q == ccsc_pkg::ST_COMPLETE);
	reach_fault_c: cover property (
		state_q == ccsc_pkg::ST_FAST ##1 state_q == ccsc_pkg::ST_TFAULT);
	recharge_c: cover property (
		state_q == ccsc_pkg::ST_COMPLETE ##1 state_q == ccsc_pkg::ST_QUAL);

endmodule : ccsc_charge_ctrl

/* File: rtl/ccsc_defines.svh */
// Purpose: constants of the charge cycle state controller
// Assumes: 20 MHz system clock
// Notes:   offsets are byte addresses on the register bus
`ifndef CCSC_DEFINES_SVH
`define CCSC_DEFINES_SVH

// register offsets
`define CCSC_CTRL_OFF     12'h000
`define CCSC_STATUS_OFF   12'h004
`define CCSC_TIMER_OFF    12'h008

// control register fields and reset value
`define CCSC_CTRL_HOLD_BIT  0
`define CCSC_CTRL_RESET     32'h0000_0000

// status register field positions
`define CCSC_ST_STATE_LSB   0
`define CCSC_ST_TSUSP_BIT   8
`define CCSC_ST_DSUSP_BIT   9
`define CCSC_ST_EXP_BIT     10
`define CCSC_ST_REDUCE_BIT  11

// timing: clock rate, tick period, filter and safety periods
`define CCSC_CLK_MHZ        20
`define CCSC_TICK_US        10
`define CCSC_TERM_FILT_US   1000
`define CCSC_SAFETY_HOURS   4

`endif

/* File: rtl/ccsc_pkg.sv */
// Purpose: shared types of the charge cycle state controller
// Assumes: one-hot state coding
// Notes:   constants live in ccsc_defines.svh
package ccsc_pkg;

	// charge cycle states, one-hot
	typedef enum logic [7:0] {
		ST_OFF      = 8'h01,
		ST_NOBAT    = 8'h02,
		ST_QUAL     = 8'h04,
		ST_PRECOND  = 8'h08,
		ST_FAST     = 8'h10,
		ST_CV       = 8'h20,
		ST_COMPLETE = 8'h40,
		ST_TFAULT   = 8'h80
	} ccsc_state_t;

	// analog comparator flags, all active high
	typedef struct packed {
		logic in_present;     // input above lockout and above battery
		logic bat_present;    // battery detected
		logic above_precond;  // battery above preconditioning level
		logic at_reg;         // battery at regulation level
		logic below_recharge; // battery below recharge level
		logic term_below;     // averaged current below termination
		logic die_hot;        // die above 150 C
		logic die_cooled;     // die cooled about 10 C below trip
		logic thermistor_sense_ok;       // thermistor inside 0.25 V .. 1.24 V
		logic vin_at_fold;    // input down to foldback threshold
		logic fold_tied_in;   // foldback input tied to supply
		logic iin_at_limit;   // input current at selected limit
		logic sys_over;       // system demand above input capability
		logic bat_low;        // low battery alarm level
	} ccsc_flags_t;

endpackage : ccsc_pkg

/* File: verification/ccsc_status_host.sv */
// Purpose: host model reading the three open-drain status pins
// Assumes: each pin is pulled up to the input supply
// Notes:   a driven-high pin reads unknown, as a fight with the pull-up
`timescale 1ns/1ps
module ccsc_status_host (
	input  wire logic a_n_i,
	input  wire logic a_n_oe_i,
	input  wire logic b_n_i,
	input  wire logic b_n_oe_i,
	input  wire logic pg_n_i,
	input  wire logic pg_n_oe_i,
	output logic      a_pin_o,
	output logic      b_pin_o,
	output logic      pg_pin_o
);
	// pull-up wins when released, a sink pulls low
	assign a_pin_o  = a_n_oe_i ? (a_n_i ? 1'bx : 1'b0) : 1'b1;
	assign b_pin_o  = b_n_oe_i ? (b_n_i ? 1'bx : 1'b0) : 1'b1;
	assign pg_pin_o = pg_n_oe_i ? (pg_n_i ? 1'bx : 1'b0) : 1'b1;
endmodule : ccsc_status_host

/* File: verification/charge_cycle_state_controller_bench.sv */
// Purpose: self-checking bench of the charge cycle state controller
// Assumes: safety period shortened to a few ticks
// Notes:   state is polled through the status register
`timescale 1ns/1ps
`include "ccsc_defines.svh"
module charge_cycle_state_controller_bench;
	localparam logic [31:0] SAFETY = 32'h0000_0005;
	logic                  mclk_i   = 1'b0;
	logic                  resetn_i = 1'b0;
	ccsc_pkg::ccsc_flags_t fl       = '0;
	logic                  ce       = 1'b0;
	logic                  te_n     = 1'b1;
	logic                  psel     = 1'b0;
	logic                  penable  = 1'b0;
	logic                  pwrite   = 1'b0;
	logic [11:0]           paddr    = 12'h000;
	logic [31:0]           pwdata   = 32'h0;
	logic [31:0]           prdata;
	logic [31:0]           rd;
	logic [31:0]           rd2;
	logic                  err;
	logic                  pready, pslverr, chg_on, tenth, cv, reduce, bpath;
	logic                  a_n, a_oe, b_n, b_oe, pg_n, pg_oe;
	logic                  a_pin, b_pin, pg_pin;
	int                    failures   = 0;
	int                    n_compared = 0;
	time                   t0;

	// 20 MHz clock
	always #25 mclk_i = ~mclk_i;

	ccsc_charge_ctrl #(.SAFETY_TICKS(SAFETY)) u_ccsc_charge_ctrl (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .flags_i(fl),
		.charge_enable_i(ce), .safety_timer_enable_n_i(te_n),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .charge_on_o(chg_on),
		.current_tenth_o(tenth), .cv_mode_o(cv), .current_reduce_o(reduce),
		.battery_path_on_o(bpath), .charge_status_a_n_o(a_n),
		.charge_status_a_n_oe_o(a_oe), .charge_status_b_n_o(b_n),
		.charge_status_b_n_oe_o(b_oe), .input_good_n_o(pg_n),
		.input_good_n_oe_o(pg_oe));

	ccsc_status_host u_ccsc_status_host (
		.a_n_i(a_n), .a_n_oe_i(a_oe), .b_n_i(b_n), .b_n_oe_i(b_oe),
		.pg_n_i(pg_n), .pg_n_oe_i(pg_oe), .a_pin_o(a_pin),
		.b_pin_o(b_pin), .pg_pin_o(pg_pin));

	// compare one value and count it
	task automatic check_val(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check_val

	// compare the three pin levels seen by the host
	task automatic check_pins(input logic a, input logic b, input logic g);
		check_val("status a pin", {31'h0, a}, {31'h0, a_pin});
		check_val("status b pin", {31'h0, b}, {31'h0, b_pin});
		check_val("input good pin", {31'h0, g}, {31'h0, pg_pin});
	endtask : check_pins

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] addr,
		input logic [31:0] wd);
		int n;
		@(posedge mclk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge mclk_i);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk_i);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		check_val("pready", 1, {31'h0, pready});
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// let flags pass the synchroniser and reach the outputs
	task automatic settle();
		repeat (6) @(posedge mclk_i);
	endtask : settle

	// poll the state field until it matches or reads run out
	task automatic wait_state(input logic [7:0] s, input int maxr);
		int i;
		i = 0;
		do
		begin
			apb(1'b0, `CCSC_STATUS_OFF, 32'h0);
			i++;
		end
		while (rd[7:0] !== s && i < maxr);
		check_val("state", {24'h0, s}, {24'h0, rd[7:0]});
		settle();
	endtask : wait_state

	// reset values, refusals and a read-write register
	task automatic t_regs();
		apb(1'b0, `CCSC_CTRL_OFF, 32'h0);
		check_val("ctrl reset", `CCSC_CTRL_RESET, rd);
		apb(1'b0, `CCSC_STATUS_OFF, 32'h0);
		check_val("status reset", 32'h0000_0001, rd & 32'h0000_00ff);
		apb(1'b0, 12'h00c, 32'h0);
		check_val("unmapped error", 1, {31'h0, err});
		apb(1'b1, `CCSC_STATUS_OFF, 32'h0000_00ff);
		check_val("read-only error", 1, {31'h0, err});
		apb(1'b1, `CCSC_CTRL_OFF, 32'h0000_0001);
		apb(1'b0, `CCSC_CTRL_OFF, 32'h0);
		check_val("ctrl readback", 32'h0000_0001, rd);
		apb(1'b1, `CCSC_CTRL_OFF, 32'h0);
	endtask : t_regs

	// preconditioning, fast charge and constant voltage
	task automatic t_charge();
		@(posedge mclk_i);
		fl.in_present <= 1'b1;
		fl.bat_present <= 1'b1;
		fl.thermistor_sense_ok <= 1'b1;
		ce <= 1'b1;
		wait_state(ccsc_pkg::ST_PRECOND, 20);
		check_val("tenth", 1, {31'h0, tenth});
		check_pins(1'b0, 1'b1, 1'b0);
		@(posedge mclk_i);
		fl.above_precond <= 1'b1;
		wait_state(ccsc_pkg::ST_FAST, 20);
		check_val("tenth", 0, {31'h0, tenth});
		check_pins(1'b0, 1'b1, 1'b0);
		@(posedge mclk_i);
		fl.at_reg <= 1'b1;
		wait_state(ccsc_pkg::ST_CV, 20);
		check_val("cv mode", 1, {31'h0, cv});
	endtask : t_charge

	// short dip ignored, full dip terminates, then recharge
	task automatic t_term();
		@(posedge mclk_i);
		fl.term_below <= 1'b1;
		repeat (15000) @(posedge mclk_i);
		fl.term_below <= 1'b0;
		settle();
		check_val("cv kept", 1, {31'h0, cv});
		@(posedge mclk_i);
		fl.term_below <= 1'b1;
		t0 = $time;
		wait_state(ccsc_pkg::ST_COMPLETE, 9000);
		check_val("full filter", 1, {31'h0, ($time - t0) >= 1000000});
		check_val("charge on", 0, {31'h0, chg_on});
		check_pins(1'b1, 1'b0, 1'b0);
		@(posedge mclk_i);
		fl.at_reg <= 1'b0;
		fl.term_below <= 1'b0;
		fl.below_recharge <= 1'b1;
		wait_state(ccsc_pkg::ST_FAST, 20);
		check_val("charge on", 1, {31'h0, chg_on});
		@(posedge mclk_i);
		fl.below_recharge <= 1'b0;
	endtask : t_term

	// thermistor suspend freezes timer; expiry latches a fault
	task automatic t_fault();
		@(posedge mclk_i);
		te_n <= 1'b0;
		// let the timer count two or three ticks before suspending
		repeat (500) @(posedge mclk_i);
		fl.thermistor_sense_ok <= 1'b0;
		settle();
		check_val("charge on", 0, {31'h0, chg_on});
		check_pins(1'b0, 1'b0, 1'b0);
		apb(1'b0, `CCSC_TIMER_OFF, 32'h0);
		rd2 = rd;
		check_val("timer running", 1, {31'h0, rd2 != 32'h0});
		repeat (600) @(posedge mclk_i);
		apb(1'b0, `CCSC_TIMER_OFF, 32'h0);
		check_val("timer frozen", rd2, rd);
		@(posedge mclk_i);
		fl.thermistor_sense_ok <= 1'b1;
		settle();
		check_val("charge on", 1, {31'h0, chg_on});
		apb(1'b0, `CCSC_TIMER_OFF, 32'h0);
		check_val("timer kept", 1, {31'h0, rd >= rd2});
		wait_state(ccsc_pkg::ST_TFAULT, 400);
		check_val("charge on", 0, {31'h0, chg_on});
		check_pins(1'b0, 1'b0, 1'b0);
		repeat (400) @(posedge mclk_i);
		wait_state(ccsc_pkg::ST_TFAULT, 1);
		@(posedge mclk_i);
		fl.bat_present <= 1'b0;
		wait_state(ccsc_pkg::ST_NOBAT, 20);
		check_pins(1'b1, 1'b1, 1'b0);
		@(posedge mclk_i);
		te_n <= 1'b1;
		fl.bat_present <= 1'b1;
		wait_state(ccsc_pkg::ST_FAST, 20);
		apb(1'b0, `CCSC_TIMER_OFF, 32'h0);
		check_val("timer restart", 32'h0, rd);
	endtask : t_fault

	// die shutdown with hysteresis
	task automatic t_die();
		@(posedge mclk_i);
		fl.die_hot <= 1'b1;
		settle();
		check_val("charge on", 0, {31'h0, chg_on});
		@(posedge mclk_i);
		fl.die_hot <= 1'b0;
		settle();
		check_val("charge on", 0, {31'h0, chg_on});
		@(posedge mclk_i);
		fl.die_cooled <= 1'b1;
		settle();
		check_val("charge on", 1, {31'h0, chg_on});
	endtask : t_die

	// foldback, input limit, battery path and no-input pins
	task automatic t_power();
		@(posedge mclk_i);
		fl.vin_at_fold <= 1'b1;
		settle();
		check_val("reduce", 1, {31'h0, reduce});
		@(posedge mclk_i);
		fl.fold_tied_in <= 1'b1;
		settle();
		check_val("reduce", 0, {31'h0, reduce});
		@(posedge mclk_i);
		fl.iin_at_limit <= 1'b1;
		settle();
		check_val("reduce", 1, {31'h0, reduce});
		check_val("charge on", 1, {31'h0, chg_on});
		check_val("battery path", 1, {31'h0, bpath});
		@(posedge mclk_i);
		fl.iin_at_limit <= 1'b0;
		fl.sys_over <= 1'b1;
		settle();
		check_val("battery path", 1, {31'h0, bpath});
		@(posedge mclk_i);
		fl.sys_over <= 1'b0;
		settle();
		check_val("battery path", 0, {31'h0, bpath});
		@(posedge mclk_i);
		fl.in_present <= 1'b0;
		settle();
		check_val("battery path", 1, {31'h0, bpath});
		check_pins(1'b1, 1'b1, 1'b1);
		@(posedge mclk_i);
		fl.bat_low <= 1'b1;
		settle();
		check_pins(1'b0, 1'b1, 1'b1);
	endtask : t_power

	// charge enable low stops the charger, high restarts it
	task automatic t_disable();
		@(posedge mclk_i);
		fl.in_present <= 1'b1;
		fl.bat_low <= 1'b0;
		ce <= 1'b0;
		wait_state(ccsc_pkg::ST_OFF, 20);
		check_val("charge on", 0, {31'h0, chg_on});
		check_val("input good pin", 0, {31'h0, pg_pin});
		@(posedge mclk_i);
		ce <= 1'b1;
		wait_state(ccsc_pkg::ST_FAST, 20);
	endtask : t_disable

	// verdict and end of run
	task automatic print_verdict();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	// main sequence
	initial
	begin
		repeat (10) @(posedge mclk_i);
		resetn_i <= 1'b1;
		t_regs();
		t_charge();
		t_term();
		t_fault();
		t_die();
		t_power();
		t_disable();
		print_verdict();
	end

	// watchdog: run needs about 40k cycles, stop at 80k
	initial
	begin
		#4000000;
		failures++;
		print_verdict();
	end
endmodule : charge_cycle_state_controller_bench
